// ### aal_core.sv
// datapath executing the four accumulator add/and instructions
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module aal_core
	import aal_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic instr_valid,
	input wire logic [13:0] instr,
	input wire logic flags_we,
	input wire aal_flags_t flags_wdata,
	input wire logic [6:0] dbg_addr,
	output logic [7:0] dbg_rdata,
	output logic [7:0] w_out,
	output aal_flags_t flags_out,
	output logic done
);
	// ==========================================================
	// decode
	function automatic aal_op_t decode(input logic [13:0] ir);
		aal_op_t op;
		op = AAL_NONE;
		if (ir[13:9] == OP_ADD_LIT[5:1])
			op = AAL_ADD_LIT;
		else if (ir[13:8] == OP_AND_LIT)
			op = AAL_AND_LIT;
		else if (ir[13:8] == OP_ADD_FILE)
			op = AAL_ADD_FILE;
		else if (ir[13:8] == OP_AND_FILE)
			op = AAL_AND_FILE;
		return op;
	endfunction

	logic [7:0] w_q, w_d;
	aal_flags_t fl_q, fl_d;
	logic [7:0] file_q [REG_DEPTH];
	logic [7:0] file_d;
	logic file_we;
	logic [6:0] faddr;
	logic done_q, done_d;
	logic [7:0] dbg_q, dbg_d;
	aal_op_t op;
	logic [7:0] operand, res;
	logic [8:0] sum;
	logic [4:0] low_sum;
	logic is_add, to_file;

	// ==========================================================
	// execute
	always_comb begin
		op = instr_valid ? decode(instr) : AAL_NONE;
		faddr = instr[ADDR_W-1:0];
		operand = (op == AAL_ADD_FILE || op == AAL_AND_FILE) ?
			file_q[faddr] : instr[7:0];
		sum = {1'b0, w_q} + {1'b0, operand};
		low_sum = {1'b0, w_q[3:0]} + {1'b0, operand[3:0]};
		is_add = (op == AAL_ADD_LIT || op == AAL_ADD_FILE);
		res = is_add ? sum[7:0] : (w_q & operand);
		to_file = (op == AAL_ADD_FILE || op == AAL_AND_FILE) &&
			instr[DEST_BIT];
		w_d = w_q;
		fl_d = flags_we ? flags_wdata : fl_q;
		file_we = 1'b0;
		file_d = res;
		done_d = 1'b0;
		if (op != AAL_NONE) begin
			done_d = 1'b1;
			if (to_file)
				file_we = 1'b1;
			else
				w_d = res;
			fl_d.zero = (res == 8'h00);
			if (is_add) begin
				fl_d.carry = sum[8];
				fl_d.half_carry_flag = low_sum[4];
			end
		end
		dbg_d = file_q[dbg_addr];
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			w_q <= W_RESET;
			fl_q <= '0;
			done_q <= 1'b0;
			dbg_q <= 8'h00;
		end else begin
			w_q <= w_d;
			fl_q <= fl_d;
			done_q <= done_d;
			dbg_q <= dbg_d;
		end
	end

	// file storage holds no reset, as real register ram
	always_ff @(posedge core_clk) begin
		if (file_we)
			file_q[faddr] <= file_d;
	end

	assign w_out = w_q;
	assign flags_out = fl_q;
	assign done = done_q;
	assign dbg_rdata = dbg_q;

	// ==========================================================
	// checks
	property p_add_lit;
		@(posedge core_clk) disable iff (srst)
		(op == AAL_ADD_LIT) |=>
			(w_q == 8'($past(w_q) + $past(instr[7:0]))) &&
			(fl_q.carry == $past(sum[8]));
	endproperty
	a_add_lit: assert property (p_add_lit)
		else $error("literal add result wrong");

	property p_and_lit;
		@(posedge core_clk) disable iff (srst)
		(op == AAL_AND_LIT && !flags_we) |=>
			(w_q == ($past(w_q) & $past(instr[7:0]))) &&
			$stable(fl_q.carry) && $stable(fl_q.half_carry_flag);
	endproperty
	a_and_lit: assert property (p_and_lit)
		else $error("literal and wrong");

	property p_add_file;
		@(posedge core_clk) disable iff (srst)
		(op == AAL_ADD_FILE) |=>
			(fl_q.half_carry_flag == ((5'($past(w_q[3:0])) +
			5'($past(operand[3:0]))) > 5'h0f)) &&
			(fl_q.zero == ($past(sum[7:0]) == 8'h00));
	endproperty
	a_add_file: assert property (p_add_file)
		else $error("file add flags wrong");

	property p_and_file;
		@(posedge core_clk) disable iff (srst)
		(op == AAL_AND_FILE && !flags_we) |=>
			$stable(fl_q.carry) &&
			(fl_q.zero == ($past(res) == 8'h00));
	endproperty
	a_and_file: assert property (p_and_file)
		else $error("file and flags wrong");

	property p_dest_file;
		@(posedge core_clk) disable iff (srst)
		to_file |=> $stable(w_q) && file_q[$past(faddr)] == $past(res);
	endproperty
	a_dest_file: assert property (p_dest_file)
		else $error("file destination wrong");

	property p_dest_w;
		@(posedge core_clk) disable iff (srst)
		(op inside {AAL_ADD_FILE, AAL_AND_FILE} && !instr[DEST_BIT]) |=>
			(w_q == $past(res));
	endproperty
	a_dest_w: assert property (p_dest_w)
		else $error("w destination wrong");

	property p_done;
		@(posedge core_clk) disable iff (srst)
		(op != AAL_NONE) |=> done ##1 (done == $past(op != AAL_NONE));
	endproperty
	a_done: assert property (p_done)
		else $error("completion not single cycle");

	property p_idle;
		@(posedge core_clk) disable iff (srst)
		(op == AAL_NONE) |=> $stable(w_q) && !done;
	endproperty
	a_idle: assert property (p_idle)
		else $error("w changed without instruction");

	property p_add_lit_flags;
		@(posedge core_clk) disable iff (srst)
		(op == AAL_ADD_LIT) |=> (fl_q.zero == (w_q == 8'h00)) &&
			(fl_q.half_carry_flag == ((5'($past(w_q[3:0])) +
			5'($past(instr[3:0]))) > 5'h0f));
	endproperty
	a_add_lit_flags: assert property (p_add_lit_flags)
		else $error("literal add zero or half carry wrong");

	property p_add_file_carry;
		@(posedge core_clk) disable iff (srst)
		(op == AAL_ADD_FILE) |=>
			(fl_q.carry ==
			((9'($past(w_q)) + 9'($past(operand))) > 9'h0ff));
	endproperty
	a_add_file_carry: assert property (p_add_file_carry)
		else $error("file add carry wrong");

	property p_and_lit_zero;
		@(posedge core_clk) disable iff (srst)
		(op == AAL_AND_LIT) |=> (fl_q.zero == (w_q == 8'h00));
	endproperty
	a_and_lit_zero: assert property (p_and_lit_zero)
		else $error("literal and zero flag wrong");

	property p_file_keep;
		@(posedge core_clk) disable iff (srst)
		(op inside {AAL_ADD_FILE, AAL_AND_FILE} && !instr[DEST_BIT]) |=>
			(file_q[$past(faddr)] == $past(operand));
	endproperty
	a_file_keep: assert property (p_file_keep)
		else $error("file register changed with w destination");

	property p_flags_hold;
		@(posedge core_clk) disable iff (srst)
		(op == AAL_NONE && !flags_we) |=> $stable(fl_q);
	endproperty
	a_flags_hold: assert property (p_flags_hold)
		else $error("flags changed without instruction");

	property p_and_file_w;
		@(posedge core_clk) disable iff (srst)
		(op == AAL_AND_FILE && !instr[DEST_BIT]) |=>
			(w_q == ($past(w_q) & $past(operand)));
	endproperty
	a_and_file_w: assert property (p_and_file_w)
		else $error("file and result wrong");
endmodule // aal_core

// ### aal_pkg.sv
// package for the accumulator add/and datapath slice
// Notes on behaviour
// - literal add updates W, carry, half carry, zero
// - literal and updates W, only Z
// - file add sums W and file, all flags
// - file and with W, only Z
// - destination bit selects W or file
package aal_pkg;
	// ==========================================================
	// instruction fields
	localparam int unsigned INSTR_W = 14;
	localparam int unsigned ADDR_W = 7;
	localparam int unsigned DEST_BIT = 7;
	localparam logic [5:0] OP_ADD_LIT = 6'h3e; // 11 111x, low bit ignored
	localparam logic [5:0] OP_AND_LIT = 6'h39; // 11 1001
	localparam logic [5:0] OP_ADD_FILE = 6'h07; // 00 0111
	localparam logic [5:0] OP_AND_FILE = 6'h05; // 00 0101
	localparam logic [7:0] W_RESET = 8'h00;
	localparam int unsigned REG_DEPTH = 128;

	typedef enum logic [2:0] {
		AAL_NONE, AAL_ADD_LIT, AAL_AND_LIT, AAL_ADD_FILE, AAL_AND_FILE
	} aal_op_t;

	typedef struct packed {
		logic carry;
		logic half_carry_flag;
		logic zero;
	} aal_flags_t;
endpackage

// ### test_add_and_literal_file_ops.sv
// self-checking bench for the accumulator add/and slice
`timescale 1ns/1ps
module test_add_and_literal_file_ops import aal_pkg::*; ;
	logic core_clk = 0, srst = 1, instr_valid = 0, flags_we = 0;
	logic [13:0] instr = 14'h0000;
	aal_flags_t flags_wdata = 3'b000;
	logic [6:0] dbg_addr = 7'h00;
	logic [7:0] dbg_rdata, w_out;
	aal_flags_t flags_out;
	logic done;
	int mismatches = 0, check_count = 0;

	always #4 core_clk = ~core_clk;

	aal_core DUT (.core_clk(core_clk), .srst(srst),
		.instr_valid(instr_valid), .instr(instr), .flags_we(flags_we),
		.flags_wdata(flags_wdata), .dbg_addr(dbg_addr),
		.dbg_rdata(dbg_rdata), .w_out(w_out), .flags_out(flags_out),
		.done(done));

	// ========
	// tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// flags given as {carry, half, zero}; results land one cycle later
	task automatic op(input logic [13:0] i, input logic [7:0] w,
		input logic [2:0] f, input logic dn);
		@(posedge core_clk);
		instr <= i;
		instr_valid <= 1'b1;
		@(posedge core_clk);
		instr_valid <= 1'b0;
		#1;
		check({7'h00, done}, {7'h00, dn});
		check(w_out, w);
		check({5'h00, flags_out}, {5'h00, f});
	endtask

	task automatic peek(input logic [6:0] a, input logic [7:0] v);
		@(posedge core_clk);
		dbg_addr <= a;
		@(posedge core_clk);
		#1;
		check(dbg_rdata, v);
	endtask

	task automatic setf(input logic [2:0] f);
		@(posedge core_clk);
		flags_we <= 1'b1;
		flags_wdata <= f;
		@(posedge core_clk);
		flags_we <= 1'b0;
		#1;
		check({5'h00, flags_out}, {5'h00, f});
	endtask

	task automatic results();
		$display("mismatches %0d checks %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ========
	// sequence
	initial begin
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		#1;
		check(w_out, 8'h00);
		op(14'h3900, 8'h00, 3'b001, 1'b1);
		// file ram is not reset: and with w=0 clears it
		op(14'h0585, 8'h00, 3'b001, 1'b1);
		peek(7'h05, 8'h00);
		op(14'h3E17, 8'h17, 3'b000, 1'b1);
		op(14'h0785, 8'h17, 3'b000, 1'b1);
		op(14'h3900, 8'h00, 3'b001, 1'b1);
		op(14'h3FAB, 8'hAB, 3'b000, 1'b1);
		op(14'h0785, 8'hAB, 3'b010, 1'b1);
		peek(7'h05, 8'hC2);
		op(14'h3900, 8'h00, 3'b011, 1'b1);
		op(14'h3E17, 8'h17, 3'b000, 1'b1);
		op(14'h0705, 8'hD9, 3'b000, 1'b1);
		peek(7'h05, 8'hC2);
		op(14'h3E27, 8'h00, 3'b111, 1'b1);
		op(14'h39FF, 8'h00, 3'b111, 1'b1);
		op(14'h3E10, 8'h10, 3'b000, 1'b1);
		op(14'h3E15, 8'h25, 3'b000, 1'b1);
		setf(3'b110);
		op(14'h3905, 8'h05, 3'b110, 1'b1);
		op(14'h0585, 8'h05, 3'b111, 1'b1);
		peek(7'h05, 8'h00);
		op(14'h3E03, 8'h08, 3'b000, 1'b1);
		op(14'h0505, 8'h00, 3'b001, 1'b1);
		// other opcodes leave w, flags and file untouched and raise no done
		op(14'h3800, 8'h00, 3'b001, 1'b0);
		// back to back: second op builds on the first
		@(posedge core_clk);
		instr <= 14'h3E40;
		instr_valid <= 1'b1;
		@(posedge core_clk);
		instr <= 14'h3E0F;
		#1;
		check(w_out, 8'h40);
		@(posedge core_clk);
		instr_valid <= 1'b0;
		#1;
		check(w_out, 8'h4F);
		check({5'h00, flags_out}, 8'h00);
		check({7'h00, done}, 8'h01);
		results();
	end
endmodule // test_add_and_literal_file_ops
